//--- core/edsag_pkg.sv
// Constants, register map and addressing modes of the paged address generator
`default_nettype none

package edsag_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int EA_W       = 16;
   localparam int XADDR_W    = 24;
   localparam int RPAGE_W    = 10;
   localparam int WPAGE_W    = 9;
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 16;

   // ----------------------------------------------------------------
   // Register map (word index on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [REG_ADDR_W-1:0] REG_READ_PAGE  = 4'h0;
   localparam logic [REG_ADDR_W-1:0] REG_WRITE_PAGE = 4'h1;

   // ----------------------------------------------------------------
   // Page values
   // ----------------------------------------------------------------
   localparam logic [RPAGE_W-1:0] PAGE_ZERO     = 10'h000;
   localparam logic [RPAGE_W-1:0] PAGE_RESET    = 10'h001;
   localparam logic [RPAGE_W-1:0] PAGE_FIRST    = 10'h001;
   localparam logic [RPAGE_W-1:0] PAGE_EDS_LAST = 10'h1ff;
   localparam logic [RPAGE_W-1:0] PAGE_PSV_LO0  = 10'h200;
   localparam logic [RPAGE_W-1:0] PAGE_PSV_LOZ  = 10'h2ff;
   localparam logic [RPAGE_W-1:0] PAGE_PSV_HI0  = 10'h300;
   localparam logic [RPAGE_W-1:0] PAGE_PSV_HIZ  = 10'h3ff;
   localparam logic [RPAGE_W-1:0] PAGE_STEP     = 10'h001;

   // ----------------------------------------------------------------
   // Bit positions
   // ----------------------------------------------------------------
   localparam int EA_PAGED_BIT = 15;
   localparam int PSV_SEL_BIT  = 9;

   // ----------------------------------------------------------------
   // Addressing modes of the current access
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_PLAIN   = 3'b000,
      MODE_POSTMOD = 3'b001,
      MODE_PREMOD  = 3'b010,
      MODE_REGOFS  = 3'b011,
      MODE_MODULO  = 3'b100,
      MODE_BITREV  = 3'b101
   } edsag_mode_t;

endpackage : edsag_pkg

`default_nettype wire

//--- core/edsag_top.sv
// Paged extended data space address generator with page registers
//
// Decided for this implementation: the address map and the plain strobed port.
`default_nettype none

// Function
// - Read page register is 10 bits, write page register 9 bits, software reachable.
// - Read page 9 clear and address bit 15 set: page bits above address bits.
// - Write with address bit 15 set: write page bits above address bits.
// - Read page 0x200 upward selects program space; write page only data space.
// - Writes aimed at program space raise an address error trap instead.
// - Paged access with a zero page raises an address error trap.
// - Page crossing only counted for paged start address and pre/post modified modes.
// - Overflow normally increments page and forces address bit 15 high.
// - Underflow normally decrements page and forces address bit 15 high.
// - Offset, modulo, bit reversed crossing: set bit 15, keep page.
// - Terminal pages keep the page and clear bit 15 into base space.
// - Read overflow 0x2FF goes to 0x300, underflow 0x300 back to 0x2FF.
// - Low base addresses are always reachable as page zero, bit 15 clear.
// - Both page registers reset to one.
// - Software writing zero to a page register leaves it unchanged.
// - Nonzero pages reached only with address bit 15 set.
// - Page one maps to 0x008000, page two to 0x010000, and onward.
// - Read page serves sources, write page destinations, independently.
module edsag_top
   import edsag_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [REG_ADDR_W-1:0] regAddr,
   input  wire logic [REG_DATA_W-1:0] regWrData,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output var  logic [REG_DATA_W-1:0] regRdData,
   input  wire logic                  reqValid,
   input  wire logic                  reqWrite,
   input  wire logic                  reqProgDest,
   input  wire logic [2:0]            reqMode,
   input  wire logic                  reqDec,
   input  wire logic [EA_W-1:0]       reqEaOld,
   input  wire logic [EA_W-1:0]       reqEaNew,
   output var  logic                  memValid,
   output var  logic                  memWrite,
   output var  logic                  memProg,
   output var  logic [XADDR_W-1:0]    memAddr,
   output var  logic [EA_W-1:0]       eaOut,
   output var  logic                  addrErrTrap,
   output var  logic [RPAGE_W-1:0]    readPage,
   output var  logic [WPAGE_W-1:0]    writePage
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [RPAGE_W-1:0]    rpage;
      logic [WPAGE_W-1:0]    wpage;
      logic                  memValid;
      logic                  memWrite;
      logic                  memProg;
      logic [XADDR_W-1:0]    memAddr;
      logic [EA_W-1:0]       eaOut;
      logic                  trap;
      logic [REG_DATA_W-1:0] rdData;
   } edsag_state_t;

   edsag_state_t state_r;
   edsag_state_t state_nxt;

   logic [RPAGE_W-1:0] curPage;
   logic [RPAGE_W-1:0] newPage;
   logic               ea15;
   logic               crossed;
   logic               linMode;
   logic               wrapMode;
   logic               trapNow;
   edsag_mode_t        mode;

   assign mode = edsag_mode_t'(reqMode);

   // ----------------------------------------------------------------
   // Address generation and page update
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      // Source uses the read page, destination the write page
      curPage   = reqWrite ? {1'b0, state_r.wpage} : state_r.rpage;
      newPage   = curPage;
      ea15      = reqEaNew[EA_PAGED_BIT];
      // Crossing counted only when the start address was already paged
      crossed   = reqEaOld[EA_PAGED_BIT] & ~reqEaNew[EA_PAGED_BIT];
      linMode   = (mode == MODE_POSTMOD) || (mode == MODE_PREMOD);
      wrapMode  = (mode == MODE_REGOFS) || (mode == MODE_MODULO)
                  || (mode == MODE_BITREV);
      trapNow   = 1'b0;

      if (crossed && linMode)
      begin
         if (!reqDec)
         begin
            if ((curPage == PAGE_EDS_LAST)
                || (!reqWrite && (curPage == PAGE_PSV_HIZ)))
            begin
               ea15 = 1'b0;
            end
            else if (!reqWrite && (curPage == PAGE_PSV_LOZ))
            begin
               newPage = PAGE_PSV_HI0;
               ea15    = 1'b1;
            end
            else
            begin
               newPage = curPage + PAGE_STEP;
               ea15    = 1'b1;
            end
         end
         else
         begin
            // Write underflow below page one drops to base space too
            if ((curPage == PAGE_FIRST)
                || (!reqWrite && (curPage == PAGE_PSV_LO0)))
            begin
               ea15 = 1'b0;
            end
            else if (!reqWrite && (curPage == PAGE_PSV_HI0))
            begin
               newPage = PAGE_PSV_LOZ;
               ea15    = 1'b1;
            end
            else
            begin
               newPage = curPage - PAGE_STEP;
               ea15    = 1'b1;
            end
         end
      end
      else if (crossed && wrapMode)
      begin
         ea15 = 1'b1;
      end

      // Zero page is never valid through the upper window
      if (ea15 && (newPage == PAGE_ZERO))
      begin
         trapNow = 1'b1;
      end
      // Write page cannot reach program space; such writes are refused
      if (reqWrite && reqProgDest)
      begin
         trapNow = 1'b1;
      end

      state_nxt.memValid = 1'b0;
      state_nxt.trap     = 1'b0;
      if (reqValid)
      begin
         state_nxt.memWrite = reqWrite;
         state_nxt.eaOut    = {ea15, reqEaNew[EA_PAGED_BIT-1:0]};
         if (trapNow)
         begin
            // Offending access suppressed, pages left as they were
            state_nxt.trap = 1'b1;
         end
         else
         begin
            state_nxt.memValid = 1'b1;
            if (ea15)
            begin
               // Page bits sit directly above the 15-bit window offset
               state_nxt.memAddr = {newPage[WPAGE_W-1:0],
                                    reqEaNew[EA_PAGED_BIT-1:0]};
               state_nxt.memProg = ~reqWrite & newPage[PSV_SEL_BIT];
            end
            else
            begin
               state_nxt.memAddr = {{(XADDR_W-EA_W+1){1'b0}},
                                    reqEaNew[EA_PAGED_BIT-1:0]};
               state_nxt.memProg = 1'b0;
            end
            if (reqWrite)
            begin
               state_nxt.wpage = newPage[WPAGE_W-1:0];
            end
            else
            begin
               state_nxt.rpage = newPage;
            end
         end
      end

      // ----------------------------------------------------------------
      // Register port; a software write overrides a hardware step
      // ----------------------------------------------------------------
      if (regWr && (regAddr == REG_READ_PAGE)
          && (regWrData[RPAGE_W-1:0] != PAGE_ZERO))
      begin
         state_nxt.rpage = regWrData[RPAGE_W-1:0];
      end
      if (regWr && (regAddr == REG_WRITE_PAGE)
          && (regWrData[WPAGE_W-1:0] != PAGE_ZERO[WPAGE_W-1:0]))
      begin
         state_nxt.wpage = regWrData[WPAGE_W-1:0];
      end

      state_nxt.rdData = '0;
      if (regRd)
      begin
         unique case (regAddr)
            REG_READ_PAGE:
            begin
               state_nxt.rdData = {{(REG_DATA_W-RPAGE_W){1'b0}}, state_r.rpage};
            end
            REG_WRITE_PAGE:
            begin
               state_nxt.rdData = {{(REG_DATA_W-WPAGE_W){1'b0}}, state_r.wpage};
            end
            default:
            begin
               state_nxt.rdData = '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r          <= '0;
         state_r.rpage    <= PAGE_RESET;
         state_r.wpage    <= PAGE_RESET[WPAGE_W-1:0];
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign regRdData   = state_r.rdData;
   assign memValid    = state_r.memValid;
   assign memWrite    = state_r.memWrite;
   assign memProg     = state_r.memProg;
   assign memAddr     = state_r.memAddr;
   assign eaOut       = state_r.eaOut;
   assign addrErrTrap = state_r.trap;
   assign readPage    = state_r.rpage;
   assign writePage   = state_r.wpage;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   pass_through_a: assert property (
      memValid && !eaOut[EA_PAGED_BIT] |->
         memAddr == {{(XADDR_W-EA_W+1){1'b0}}, eaOut[EA_PAGED_BIT-1:0]})
      else $error("Base access not passed through unchanged");

   paged_addr_a: assert property (
      memValid && eaOut[EA_PAGED_BIT] |->
         memAddr[XADDR_W-1:EA_PAGED_BIT] ==
            (memWrite ? writePage : readPage[WPAGE_W-1:0]))
      else $error("Paged address does not carry the page");

   prog_select_a: assert property (
      memValid && memProg |-> !memWrite && readPage[PSV_SEL_BIT]
         && eaOut[EA_PAGED_BIT])
      else $error("Program space selected wrongly");

   trap_suppress_a: assert property (
      addrErrTrap |-> !memValid)
      else $error("Access not suppressed on trap");

   zero_page_a: assert property (
      memValid && eaOut[EA_PAGED_BIT] |->
         (memWrite ? {1'b0, writePage} : readPage) != PAGE_ZERO)
      else $error("Paged access formed with page zero");

   prog_write_a: assert property (
      reqValid && reqWrite && reqProgDest |=> addrErrTrap && !memValid)
      else $error("Program space write not trapped");

   overflow_step_a: assert property (
      reqValid && !reqWrite && !regWr && (mode == MODE_POSTMOD) && !reqDec
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (readPage > PAGE_ZERO) && (readPage < PAGE_EDS_LAST)
      |=> (readPage == $past(readPage) + PAGE_STEP) && eaOut[EA_PAGED_BIT])
      else $error("Overflow did not advance read page");

   psv_cross_a: assert property (
      reqValid && !reqWrite && !regWr && (mode == MODE_PREMOD) && !reqDec
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (readPage == PAGE_PSV_LOZ)
      |=> (readPage == PAGE_PSV_HI0) && eaOut[EA_PAGED_BIT] ##1
          (readPage == PAGE_PSV_HI0 || $past(regWr) || $past(reqValid)))
      else $error("Program view page crossing wrong");

   terminal_page_a: assert property (
      reqValid && reqWrite && !reqProgDest && !regWr && (mode == MODE_POSTMOD)
         && !reqDec && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (writePage == PAGE_EDS_LAST[WPAGE_W-1:0])
      |=> $stable(writePage) && !eaOut[EA_PAGED_BIT] && memValid)
      else $error("Terminal write page not held");

   wrap_mode_a: assert property (
      reqValid && !regWr && (mode == MODE_REGOFS)
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
      |=> $stable(readPage) && $stable(writePage) && eaOut[EA_PAGED_BIT])
      else $error("Wrap mode changed the page");

   zero_write_a: assert property (
      regWr && (regAddr == REG_READ_PAGE) && !reqValid
         && (regWrData[RPAGE_W-1:0] == PAGE_ZERO)
      |=> $stable(readPage))
      else $error("Zero written into read page");

   read_back_a: assert property (
      regRd && (regAddr == REG_WRITE_PAGE) |=>
         regRdData == {{(REG_DATA_W-WPAGE_W){1'b0}}, $past(writePage)})
      else $error("Write page read back wrong");

   underflow_step_a: assert property (
      reqValid && !reqWrite && !regWr && (mode == MODE_POSTMOD) && reqDec
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (readPage > PAGE_FIRST) && (readPage < PAGE_PSV_LO0)
      |=> (readPage == $past(readPage) - PAGE_STEP) && eaOut[EA_PAGED_BIT])
      else $error("Underflow did not step the read page back");

   write_step_a: assert property (
      reqValid && reqWrite && !reqProgDest && !regWr && (mode == MODE_PREMOD)
         && !reqDec && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (writePage < PAGE_EDS_LAST[WPAGE_W-1:0])
      |=> (writePage == $past(writePage) + PAGE_STEP[WPAGE_W-1:0])
          && eaOut[EA_PAGED_BIT])
      else $error("Overflow did not advance write page");

   psv_back_a: assert property (
      reqValid && !reqWrite && !regWr && (mode == MODE_POSTMOD) && reqDec
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (readPage == PAGE_PSV_HI0)
      |=> (readPage == PAGE_PSV_LOZ) && eaOut[EA_PAGED_BIT])
      else $error("Program view page not stepped back");

   terminal_read_a: assert property (
      reqValid && !reqWrite && !regWr && (mode == MODE_POSTMOD) && reqDec
         && reqEaOld[EA_PAGED_BIT] && !reqEaNew[EA_PAGED_BIT]
         && (readPage == PAGE_PSV_LO0)
      |=> $stable(readPage) && !eaOut[EA_PAGED_BIT] && memValid)
      else $error("Terminal read page not held");

   page_hold_a: assert property (
      reqValid && !regWr |=>
         ($past(reqWrite) ? $stable(readPage) : $stable(writePage)))
      else $error("Access moved the other page register");

   read_idle_a: assert property (
      !regRd |=> regRdData == '0)
      else $error("Read data stood beyond its cycle");

   answer_cause_a: assert property (
      memValid || addrErrTrap |-> $past(reqValid))
      else $error("Access answer without a request");

   trap_hold_a: assert property (
      addrErrTrap |-> ($stable(readPage) && $stable(writePage)) || $past(regWr))
      else $error("Trapped access changed a page");

endmodule : edsag_top

`default_nettype wire

//--- tb/edsag_cpu_model.sv
// CPU side model: issues effective address requests to the generator
`default_nettype none

module edsag_cpu_model
   import edsag_pkg::*;
(
   input  wire logic            sys_clk,
   output var  logic            reqValid,
   output var  logic            reqWrite,
   output var  logic            reqProgDest,
   output var  logic [2:0]      reqMode,
   output var  logic            reqDec,
   output var  logic [EA_W-1:0] reqEaOld,
   output var  logic [EA_W-1:0] reqEaNew
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reqValid    = 1'b0;
      reqWrite    = 1'b0;
      reqProgDest = 1'b0;
      reqMode     = 3'h0;
      reqDec      = 1'b0;
      reqEaOld    = 16'h0000;
      reqEaNew    = 16'h0000;
   end

   // Request stands for one taking edge; back to back calls need no gap
   task automatic issue(input logic w, p, input logic [2:0] m, input logic d,
                        input logic [EA_W-1:0] o, n);
      reqValid    <= 1'b1;
      reqWrite    <= w;
      reqProgDest <= p;
      reqMode     <= m;
      reqDec      <= d;
      reqEaOld    <= o;
      reqEaNew    <= n;
      @(posedge sys_clk);
   endtask : issue

   // Address and mode fields flip so a stale value never passes for a request
   task automatic idle();
      reqValid <= 1'b0;
      reqEaOld <= ~reqEaOld;
      reqEaNew <= ~reqEaNew;
      reqMode  <= ~reqMode;
      @(posedge sys_clk);
   endtask : idle

endmodule : edsag_cpu_model

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the paged address generator
`default_nettype none

module tb_top
   import edsag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  sys_clk, rst_n, regWr, regRd, rdSeen, lastProg;
   logic                  reqValid, reqWrite, reqProgDest, reqDec;
   logic                  memValid, memWrite, memProg, addrErrTrap;
   logic [REG_ADDR_W-1:0] regAddr;
   logic [REG_DATA_W-1:0] regWrData, regRdData;
   logic [2:0]            reqMode;
   logic [EA_W-1:0]       reqEaOld, reqEaNew, eaOut;
   logic [XADDR_W-1:0]    memAddr, lastAddr;
   logic [RPAGE_W-1:0]    readPage, rp;
   logic [WPAGE_W-1:0]    writePage, wp;
   logic [62:0]           expQ[$];
   logic [15:0]           rdQ[$];
   logic [RPAGE_W-1:0]    pgTab[7] = '{10'h001, 10'h002, 10'h1ff, 10'h200,
                                       10'h2ff, 10'h300, 10'h3ff};
   int                    errTotal = 0;
   int                    checked = 0;

   edsag_top u_edsag_top (.sys_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .reqValid, .reqWrite, .reqProgDest, .reqMode, .reqDec, .reqEaOld,
      .reqEaNew, .memValid, .memWrite, .memProg, .memAddr, .eaOut, .addrErrTrap,
      .readPage, .writePage);
   edsag_cpu_model u_edsag_cpu_model (.sys_clk, .reqValid, .reqWrite, .reqProgDest,
      .reqMode, .reqDec, .reqEaOld, .reqEaNew);

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [62:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      if (a == REG_READ_PAGE && d[9:0] != 10'h0)
         rp = d[9:0];
      if (a == REG_WRITE_PAGE && d[8:0] != 9'h0)
         wp = d[8:0];
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(posedge sys_clk);
   endtask : regWrite

   task automatic regRead(input logic [3:0] a);
      regRd   <= 1'b1;
      regAddr <= a;
      rdQ.push_back(a == REG_READ_PAGE ? {6'h0, rp} :
                    a == REG_WRITE_PAGE ? {7'h0, wp} : 16'h0);
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(posedge sys_clk);
   endtask : regRead

   // Predicts the outcome from the paging rules, then issues the request
   task automatic access(input logic w, p, input logic [2:0] m, input logic d,
                         input logic [15:0] o, n);
      logic [9:0]  pg;
      logic [15:0] ea;
      logic        trap;
      pg = w ? {1'b0, wp} : rp;
      ea = n;
      if (o[15] && !n[15] && m != 3'h0)
      begin
         ea[15] = 1'b1;
         if (m < 3'h3 && !d && (pg == 10'h1ff || (!w && pg == 10'h3ff)))
            ea[15] = 1'b0;
         else if (m < 3'h3 && d && (pg == 10'h001 || (!w && pg == 10'h200)))
            ea[15] = 1'b0;
         else if (m < 3'h3)
            pg = d ? pg - 10'h1 : pg + 10'h1;
      end
      trap = (w && p) || (ea[15] && pg == 10'h0);
      if (!trap)
      begin
         lastAddr = ea[15] ? {pg[8:0], ea[14:0]} : {8'h0, ea};
         lastProg = !w && ea[15] && pg[9];
         if (w)
            wp = pg[8:0];
         else
            rp = pg;
      end
      expQ.push_back({!trap, trap, w, lastProg, lastAddr, ea, rp, wp});
      u_edsag_cpu_model.issue(w, p, m, d, o, n);
   endtask : access

   // ----------------------------------------------------------------
   // Observer
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
      rdSeen <= regRd;

   always @(negedge sys_clk)
   begin
      if (rst_n && (memValid || addrErrTrap))
      begin
         if (expQ.size() == 0)
            check(63'h1, 63'h0);
         else
            check({memValid, addrErrTrap, memWrite, memProg, memAddr, eaOut, readPage,
                   writePage}, expQ.pop_front());
      end
      if (rst_n)
         check({47'h0, regRdData}, rdSeen ? {47'h0, rdQ.pop_front()} : 63'h0);
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errTotal++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 16'h0;
      rp = 10'h001;
      wp = 9'h001;
      lastAddr = 24'h0;
      lastProg = 1'b0;
      void'($urandom(32'habaeb5fc));
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      regRead(REG_READ_PAGE);
      regRead(REG_WRITE_PAGE);
      regWrite(REG_READ_PAGE, 16'hfc00);
      regWrite(REG_WRITE_PAGE, 16'h0200);
      regWrite(4'h5, 16'h0007);
      regRead(4'h5);
      regRead(REG_READ_PAGE);
      regRead(REG_WRITE_PAGE);
      access(1'b0, 1'b0, 3'h0, 1'b0, 16'h8000, 16'h2fff);
      access(1'b0, 1'b1, 3'h0, 1'b0, 16'h0000, 16'h8000);
      access(1'b1, 1'b1, 3'h0, 1'b0, 16'h0000, 16'h8002);
      access(1'b1, 1'b0, 3'h0, 1'b0, 16'h0000, 16'hfffe);
      u_edsag_cpu_model.idle();
      for (int i = 0; i < 10; i++)
      begin
         r = $urandom;
         regWrite(REG_READ_PAGE, {6'h0, i < 7 ? pgTab[i] : r[9:0]});
         regWrite(REG_WRITE_PAGE, {6'h0, i < 7 ? pgTab[i] : r[25:16]});
         regRead(REG_READ_PAGE);
         regRead(REG_WRITE_PAGE);
         // Every mode, direction and step sense crosses the page edge
         for (int k = 0; k < 48; k++)
         begin
            r = $urandom;
            access(k[0], 1'b0, 3'((k >> 2) % 6), k[1] ^ (k >= 24), r[15:0] | 16'h8000,
                   r[15:0] & 16'h7fff);
         end
         for (int k = 0; k < 8; k++)
         begin
            r = $urandom;
            access(r[0], r[3:1] == 3'h0, 3'(r[6:4] % 3'd6), r[8], 16'($urandom),
                   16'($urandom));
         end
         u_edsag_cpu_model.idle();
      end
      for (int t = 0; t < 20 && expQ.size() != 0; t++)
         @(posedge sys_clk);
      if (expQ.size() != 0)
         errTotal++;
      rst_n <= 1'b0;
      @(negedge sys_clk);
      check(63'({memValid, addrErrTrap, eaOut, readPage, writePage}),
            63'({10'h001, 9'h001}));
      rp = 10'h001;
      wp = 9'h001;
      lastAddr = 24'h0;
      lastProg = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      access(1'b0, 1'b0, 3'h1, 1'b1, 16'h8000, 16'h7ffe);
      u_edsag_cpu_model.idle();
      regRead(REG_READ_PAGE);
      repeat (3) @(posedge sys_clk);
      tally_and_finish();
   end

endmodule : tb_top

`default_nettype wire
